/* File: hw/slot_map_params.svh */
// constants for the cyclic process image slot map
`ifndef SLOT_MAP_PARAMS_SVH
`define SLOT_MAP_PARAMS_SVH
`define SM_STATUS_SLOT_BITS 32
`define SM_USER_BITS 64
`define SM_FAULT_BITS 64
`define SM_INPUT_BITS 160
`define SM_INPUT_MAX 154
`define SM_INPUT_BASE 26
`define SM_INPUT_CNT_W 8
`define SM_OUTPUT_BITS 96
`define SM_VIRT_BITS 64
`define SM_RCD_BITS 16
`define SM_CODE_BITS 16
`define SM_FLOG_BYTES 300
`define SM_SINFO_BYTES 30
`define SM_DIAG_BYTES 128
`define SM_DEV_IN_BYTES 24
`define SM_DEV_OUT_BYTES 6
`define SM_IN_BYTES 400
`define SM_OUT_BYTES 12
`define SM_SLOT_IN_BYTE 4
`define SM_DEV_ID 16'h0a5a
`define SM_INPUT_LO 128
`define SM_OUTST_LO 288
`define SM_FB_LO 384
`define SM_CODE_FB_LO 400
`define SM_DIAG_LO 416
`define SM_INFO_LO 1440
`define SM_USED_BITS 1632
`endif

/* File: hw/slot_map_pkg.sv */
// types for the cyclic process image slot map
`include "slot_map_params.svh"
package slot_map_pkg;
	// status produced by the device, before slot mapping
	typedef struct packed {
		logic [`SM_USER_BITS-1:0] user_status;
		logic [`SM_FAULT_BITS-1:0] fault_status;
		logic [`SM_INPUT_BITS-1:0] input_status;
		logic [`SM_OUTPUT_BITS-1:0] output_status;
	} status_t;
	// commands consumed by the device from the out slots
	typedef struct packed {
		logic [`SM_VIRT_BITS-1:0] on_off_mute_enable;
		logic [`SM_RCD_BITS-1:0] reset_cancel_delay;
		logic [`SM_CODE_BITS-1:0] actuation_code;
	} command_t;
	// optional module presence
	typedef struct packed {
		logic fault_log_en;
		logic sys_info_en;
	} module_cfg_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_LIVE = 2'b10
	} map_state_t;
endpackage

/* File: hw/cyclic_io_slot_map.sv */
// slot mapper between device state and the cyclic process image
// Notes on behaviour
// - in slots are built by the device, out slots are read by it.
// - slots 1 and 2 always carry 64 user status bits, 32 each.
// - byte 0 of a status slot holds bits 0-7, ascending after.
// - slots 3 and 4 always carry 64 fault status bits.
// - slots 5 to 9 carry 160 input status bits in ascending order.
// - up to 154 physical inputs fit within the 160 positions.
// - slots 10 to 12 carry output status bits 0 to 95.
// - slot 13 gives 64 on/off or mute enable bits to the device.
// - slot 14 gives 16 reset and cancel delay request bits.
// - slot 15 gives the 16-bit actuation code.
// - slot 16 returns feedback of the slot 14 request bits.
// - slot 17 returns a copy of the actuation code.
// - slot 18 is 300 bytes of fault log when configured.
// - slot 19 is 30 bytes of system information when configured.
// - fault log and system information absent by default.
// - slot 20 is 128 bytes of chained device diagnostics.
// - slot 21 is 24 bytes to the controller, 6 bytes from it.
// - slot 16 reflects the 16 request bits taken from slot 14.
`timescale 1ns/1ps
`default_nettype none
`include "slot_map_params.svh"
module cyclic_io_slot_map (
	input wire logic clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic cycle_strobe,
	input wire slot_map_pkg::status_t status,
	input wire logic [`SM_INPUT_CNT_W-1:0] inputs_fitted,
	input wire slot_map_pkg::module_cfg_t module_cfg,
	input wire logic [`SM_FLOG_BYTES*8-1:0] fault_log,
	input wire logic [`SM_SINFO_BYTES*8-1:0] sys_info,
	input wire logic [`SM_DIAG_BYTES*8-1:0] chained_device_diagnostics,
	input wire logic [`SM_DEV_IN_BYTES*8-1:0] chained_device_info,
	input wire logic [`SM_OUT_BYTES*8-1:0] out_image,
	input wire logic [`SM_DEV_OUT_BYTES*8-1:0] chained_device_request,
	output logic [`SM_IN_BYTES*8-1:0] in_image,
	output logic [`SM_FLOG_BYTES*8-1:0] fault_log_image,
	output logic [`SM_SINFO_BYTES*8-1:0] sys_info_image,
	output logic fault_log_present,
	output logic sys_info_present,
	output slot_map_pkg::command_t command,
	output logic [`SM_DEV_OUT_BYTES*8-1:0] chained_device_cmd,
	output logic [15:0] device_id,
	output logic image_valid
);

	// clamp of the fitted count to the documented maximum
	function automatic logic [`SM_INPUT_BITS-1:0] fitted_mask(
		input logic [`SM_INPUT_CNT_W-1:0] n);
		logic [`SM_INPUT_BITS-1:0] m;
		logic [`SM_INPUT_CNT_W-1:0] lim;
		m = '0;
		lim = (n > `SM_INPUT_CNT_W'(`SM_INPUT_MAX)) ?
			`SM_INPUT_CNT_W'(`SM_INPUT_MAX) : n;
		for (int i = 0; i < `SM_INPUT_BITS; i++)
			m[i] = (i < lim);
		return m;
	endfunction

	// unused upper part of the in image, held at zero
	localparam int PAD_BITS = `SM_IN_BYTES*8 - `SM_USED_BITS;
	slot_map_pkg::map_state_t state;
	slot_map_pkg::map_state_t next_state;

	// input status with unfitted positions zeroed
	wire [`SM_INPUT_BITS-1:0] masked_inputs;
	assign masked_inputs = status.input_status &
		fitted_mask(inputs_fitted);

	// out slot decode: 13 then 14 then 15, bytes little end first
	wire [`SM_VIRT_BITS-1:0] out_virt;
	wire [`SM_RCD_BITS-1:0] out_rcd;
	wire [`SM_CODE_BITS-1:0] out_code;
	assign out_virt = out_image[`SM_VIRT_BITS-1:0];
	assign out_rcd = out_image[`SM_VIRT_BITS+`SM_RCD_BITS-1:
		`SM_VIRT_BITS];
	assign out_code = out_image[`SM_OUT_BYTES*8-1:
		`SM_VIRT_BITS+`SM_RCD_BITS];

	// in image: slots 1-12 status, 16 and 17 feedback, 20 and 21
	// bit k of the image is byte k/8 bit k%8, so byte 0 holds bits 0-7
	wire [`SM_IN_BYTES*8-1:0] next_in_image;
	assign next_in_image = {
		{PAD_BITS{1'b0}},
		chained_device_info,
		chained_device_diagnostics,
		out_code,
		out_rcd,
		status.output_status,
		masked_inputs,
		status.fault_status,
		status.user_status
	};

	// state: idle until the first taken cycle strobe after reset
	assign next_state = cycle_strobe ? slot_map_pkg::ST_LIVE : state;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state <= slot_map_pkg::ST_IDLE;
			in_image <= '0;
			command <= '0;
			chained_device_cmd <= '0;
			image_valid <= 1'b0;
		end
		else if (clk_en)
		begin
			state <= next_state;
			image_valid <= cycle_strobe;
			if (cycle_strobe)
			begin
				in_image <= next_in_image;
				command <= {out_virt, out_rcd, out_code};
				chained_device_cmd <= chained_device_request;
			end
		end
	end

	// optional modules only present when configured
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			fault_log_present <= 1'b0;
			sys_info_present <= 1'b0;
			fault_log_image <= '0;
			sys_info_image <= '0;
			device_id <= `SM_DEV_ID; // arbitrary id value
		end
		else if (clk_en && cycle_strobe)
		begin
			fault_log_present <= module_cfg.fault_log_en;
			sys_info_present <= module_cfg.sys_info_en;
			fault_log_image <= module_cfg.fault_log_en ? fault_log : '0;
			sys_info_image <= module_cfg.sys_info_en ? sys_info : '0;
		end
	end

	// checks
	AST_FEEDBACK_ECHO: assert property (@(posedge clk) disable iff (srst)
		clk_en && cycle_strobe |=>
		in_image[`SM_FB_LO+15:`SM_FB_LO] == $past(out_rcd))
		else $error("rcd feedback mismatch");
	AST_CODE_ECHO: assert property (@(posedge clk) disable iff (srst)
		clk_en && cycle_strobe |=>
		in_image[`SM_CODE_FB_LO+15:`SM_CODE_FB_LO] == $past(out_code))
		else $error("code feedback mismatch");
	AST_CMD_RCD: assert property (@(posedge clk) disable iff (srst)
		clk_en && cycle_strobe |=>
		command.reset_cancel_delay == in_image[`SM_FB_LO+15:`SM_FB_LO])
		else $error("rcd command differs from feedback");
	AST_UNFITTED_ZERO: assert property (@(posedge clk) disable iff (srst)
		clk_en && cycle_strobe &&
		inputs_fitted <= `SM_INPUT_CNT_W'(`SM_INPUT_MAX) |=>
		(in_image[287:128] & ~fitted_mask($past(inputs_fitted))) == '0)
		else $error("unfitted input nonzero");
	AST_TOP_INPUTS_ZERO: assert property (@(posedge clk) disable iff (srst)
		image_valid |-> in_image[287:282] == 6'h00)
		else $error("inputs beyond 154 set");
	AST_USER_SLOT: assert property (@(posedge clk) disable iff (srst)
		clk_en && cycle_strobe |=>
		in_image[7:0] == $past(status.user_status[7:0]))
		else $error("slot 1 byte 0 wrong");
	AST_FAULT_SLOT: assert property (@(posedge clk) disable iff (srst)
		clk_en && cycle_strobe |=>
		in_image[127:64] == $past(status.fault_status))
		else $error("fault slots wrong");
	AST_OUT_STATUS: assert property (@(posedge clk) disable iff (srst)
		clk_en && cycle_strobe |=>
		in_image[383:288] == $past(status.output_status))
		else $error("output status wrong");
	AST_OPT_ABSENT: assert property (@(posedge clk) disable iff (srst)
		!fault_log_present |-> fault_log_image == '0)
		else $error("fault log shown while absent");
	AST_HOLD: assert property (@(posedge clk) disable iff (srst)
		!clk_en |=> $stable(in_image) && $stable(command))
		else $error("state moved while frozen");

	// slot 2 carries user bits 32 to 63
	AST_USER_HIGH: assert property (@(posedge clk)
		disable iff (srst) clk_en && cycle_strobe |=>
		in_image[63:32] == $past(status.user_status[63:32]))
		else $error("slot 2 wrong");

	// second byte of slot 1 holds bits 8 to 15
	AST_USER_BYTE1: assert property (@(posedge clk)
		disable iff (srst) clk_en && cycle_strobe |=>
		in_image[15:8] == $past(status.user_status[15:8]))
		else $error("slot 1 byte 1 wrong");

	// base unit inputs land at the bottom of slot 5
	AST_INPUT_BASE: assert property (@(posedge clk)
		disable iff (srst) clk_en && cycle_strobe && inputs_fitted >= 8'h1a |=>
		in_image[153:128] == $past(status.input_status[25:0]))
		else $error("base inputs wrong");

	// a full build passes all 154 inputs through
	AST_INPUT_ALL: assert property (@(posedge clk)
		disable iff (srst) clk_en && cycle_strobe && inputs_fitted >= 8'h9a |=>
		in_image[281:128] == $past(status.input_status[153:0]))
		else $error("full inputs wrong");

	// slot 20 diagnostics copied as they stand
	AST_DIAG: assert property (@(posedge clk)
		disable iff (srst) clk_en && cycle_strobe |=>
		in_image[1439:416] == $past(chained_device_diagnostics))
		else $error("diagnostics slot wrong");

	// slot 21 in part copied as it stands
	AST_DEV_INFO: assert property (@(posedge clk)
		disable iff (srst) clk_en && cycle_strobe |=>
		in_image[1631:1440] == $past(chained_device_info))
		else $error("device info slot wrong");

	// nothing above slot 21 in the image
	AST_REST_ZERO: assert property (@(posedge clk)
		disable iff (srst)
		image_valid |-> in_image[3199:1632] == '0)
		else $error("unused image bits set");

	// slot 13 reaches the command word
	AST_CMD_VIRT: assert property (@(posedge clk)
		disable iff (srst) clk_en && cycle_strobe |=>
		command.on_off_mute_enable == $past(out_image[63:0]))
		else $error("on off bits wrong");

	// slot 15 reaches the command word
	AST_CMD_CODE: assert property (@(posedge clk)
		disable iff (srst) clk_en && cycle_strobe |=>
		command.actuation_code == $past(out_image[95:80]))
		else $error("actuation code wrong");

	// slot 21 out part reaches the device
	AST_DEV_CMD: assert property (@(posedge clk)
		disable iff (srst) clk_en && cycle_strobe |=>
		chained_device_cmd == $past(chained_device_request))
		else $error("device request wrong");

	// valid follows every taken strobe
	AST_VALID_RISE: assert property (@(posedge clk)
		disable iff (srst)
		clk_en && cycle_strobe |=> image_valid)
		else $error("valid missing");

	// valid drops after an enabled cycle without a strobe
	AST_VALID_DROP: assert property (@(posedge clk)
		disable iff (srst)
		clk_en && !cycle_strobe |=> !image_valid)
		else $error("valid too long");

	// system information hidden while absent
	AST_INFO_ABSENT: assert property (@(posedge clk)
		disable iff (srst)
		!sys_info_present |-> sys_info_image == '0)
		else $error("system info shown while absent");

	// configured fault log copied with its presence flag
	AST_LOG_COPY: assert property (@(posedge clk)
		disable iff (srst) clk_en && cycle_strobe && module_cfg.fault_log_en
		|=> fault_log_present && fault_log_image == $past(fault_log))
		else $error("fault log copy wrong");

	// configured system information copied with its flag
	AST_INFO_COPY: assert property (@(posedge clk)
		disable iff (srst) clk_en && cycle_strobe && module_cfg.sys_info_en
		|=> sys_info_present && sys_info_image == $past(sys_info))
		else $error("system info copy wrong");

	// fault log leaves when no longer configured
	AST_LOG_OFF: assert property (@(posedge clk)
		disable iff (srst) clk_en && cycle_strobe && !module_cfg.fault_log_en
		|=> !fault_log_present)
		else $error("fault log still present");

	// system information leaves when no longer configured
	AST_INFO_OFF: assert property (@(posedge clk)
		disable iff (srst) clk_en && cycle_strobe && !module_cfg.sys_info_en
		|=> !sys_info_present)
		else $error("system info still present");

	// slot 16 taken straight from slot 14
	AST_FEEDBACK_OUT: assert property (@(posedge clk)
		disable iff (srst) clk_en && cycle_strobe |=>
		in_image[399:384] == $past(out_image[79:64]))
		else $error("feedback slot wrong");

	// first byte of slot 10 holds output bits 0 to 7
	AST_OUT_BYTE0: assert property (@(posedge clk)
		disable iff (srst) clk_en && cycle_strobe |=>
		in_image[295:288] == $past(status.output_status[7:0]))
		else $error("slot 10 byte 0 wrong");

	// image and command move only on a taken strobe
	AST_STROBE_ONLY: assert property (@(posedge clk)
		disable iff (srst) clk_en && !cycle_strobe |=>
		$stable(in_image) && $stable(command))
		else $error("image moved without strobe");

	// reset removes the optional modules
	AST_RESET_CLEAR: assert property (@(posedge clk)
		srst |=>
		!fault_log_present && !sys_info_present && !image_valid)
		else $error("reset left state");

	// slot 11 carries output bits 32 to 63
	AST_OUT_SLOT11: assert property (@(posedge clk)
		disable iff (srst) clk_en && cycle_strobe |=>
		in_image[351:320] == $past(status.output_status[63:32]))
		else $error("slot 11 wrong");

	COV_CYCLE: cover property (@(posedge clk) disable iff (srst)
		clk_en && cycle_strobe ##1 image_valid);
	COV_LOG_ON: cover property (@(posedge clk) disable iff (srst)
		$rose(fault_log_present));
	COV_INFO_ON: cover property (@(posedge clk) disable iff (srst)
		$rose(sys_info_present));
	COV_PARTIAL: cover property (@(posedge clk) disable iff (srst)
		clk_en && cycle_strobe &&
		inputs_fitted == `SM_INPUT_CNT_W'(`SM_INPUT_BASE));

endmodule // cyclic_io_slot_map
`default_nettype wire

/* File: sim/plc_model.sv */
// controller-side model that drives the out slots
`timescale 1ns/1ps
`default_nettype none
module plc_model (
	input wire logic clk,
	input wire logic [15:0] pat,
	output logic [95:0] out_image,
	output logic [47:0] chained_device_request
);
	// fresh out data every cycle, code word in the top two bytes
	always_ff @(posedge clk)
	begin
		out_image <= {pat, ~pat, {4{pat ^ 16'h0f0f}}};
		chained_device_request <= {3{pat}};
	end
endmodule // plc_model
`default_nettype wire

/* File: sim/cyclic_io_slot_map_test.sv */
// self-checking bench for the cyclic slot mapper
`timescale 1ns/1ps
`default_nettype none
`include "slot_map_params.svh"
module cyclic_io_slot_map_test;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic clk_en = 1'b1;
	logic cycle_strobe = 1'b0;
	slot_map_pkg::status_t status = '0;
	logic [7:0] inputs_fitted = 8'hff;
	slot_map_pkg::module_cfg_t module_cfg = '0;
	logic [2399:0] flog = {150{16'h3c5a}};
	logic [239:0] sinfo = {15{16'h1e2d}};
	logic [1023:0] diag = {64{16'h7788}};
	logic [191:0] info = {12{16'h4b69}};
	logic [15:0] pat = 16'h0000;
	logic [95:0] out_image;
	logic [47:0] request, dev_cmd;
	logic [3199:0] in_image;
	logic [2399:0] flog_img;
	logic [239:0] sinfo_img;
	logic flog_on, sinfo_on, image_valid;
	logic [15:0] dev_id;
	slot_map_pkg::command_t command;
	int errors = 0;
	int n_tests = 0;
	always #10 clk = ~clk;
	plc_model i_plc (.clk(clk), .pat(pat), .out_image(out_image),
		.chained_device_request(request));
	cyclic_io_slot_map i_dut (.clk(clk), .srst(srst), .clk_en(clk_en),
		.cycle_strobe(cycle_strobe), .status(status),
		.inputs_fitted(inputs_fitted), .module_cfg(module_cfg),
		.fault_log(flog), .sys_info(sinfo), .chained_device_diagnostics(diag),
		.chained_device_info(info), .out_image(out_image),
		.chained_device_request(request), .in_image(in_image),
		.fault_log_image(flog_img), .sys_info_image(sinfo_img),
		.fault_log_present(flog_on), .sys_info_present(sinfo_on),
		.command(command), .chained_device_cmd(dev_cmd), .device_id(dev_id),
		.image_valid(image_valid));
	task automatic chk(input string n, input logic [1567:0] e, s);
		n_tests++;
		if (e !== s)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic final_report;
		$display("errors %0d checks %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// one exchange; wait up to four cycles for the valid pulse and check it against want
	task automatic exchange(input logic [15:0] p, input bit want);
		int i;
		pat <= p;
		@(posedge clk);
		cycle_strobe <= 1'b1;
		@(posedge clk);
		cycle_strobe <= 1'b0;
		#1;
		for (i = 0; i < 4 && image_valid !== 1'b1; i++)
			@(posedge clk) #1;
		chk("valid", want, image_valid === 1'b1);
		if (want && image_valid !== 1'b1)
			final_report();
	endtask
	// fixed slots, clamped input count and feedback echoes
	task automatic fixed_slots;
		status <= {64'h0123456789abcdef, 64'hfedcba9876543210, {160{1'b1}},
			96'h00ff11ee22dd33cc44bb55aa};
		exchange(16'ha5c3, 1);
		chk("user", status.user_status, in_image[63:0]);
		chk("fault", status.fault_status, in_image[127:64]);
		chk("inp", {6'h0, {154{1'b1}}}, in_image[287:128]);
		chk("outp", status.output_status, in_image[383:288]);
		chk("fb", out_image[79:64], in_image[399:384]);
		chk("code", out_image[95:80], in_image[415:400]);
		chk("diag", diag, in_image[1439:416]);
		chk("info", info, in_image[1631:1440]);
		chk("rest", '0, in_image[3199:1632]);
		chk("cmd", {out_image[63:0], out_image[79:64], out_image[95:80]},
			command);
		chk("dcmd", request, dev_cmd);
	endtask
	// base unit only, then optional modules on and off
	task automatic fitted_and_options;
		inputs_fitted <= 8'h1a;
		exchange(16'h3c3c, 1);
		chk("inp26", {134'h0, 26'h3ffffff}, in_image[287:128]);
		chk("absent", 4'h0, {flog_on, sinfo_on, |flog_img, |sinfo_img});
		module_cfg <= 2'b11;
		exchange(16'h0ff0, 1);
		chk("present", 2'b11, {flog_on, sinfo_on});
		chk("flog", 1'b1, flog_img === flog);
		chk("sinfo", 1'b1, sinfo_img === sinfo);
		module_cfg <= 2'b00;
		exchange(16'h0f0f, 1);
		chk("gone", 4'h0, {flog_on, sinfo_on, |flog_img, |sinfo_img});
	endtask
	// clock enable low: a strobe is not taken
	task automatic frozen;
		@(posedge clk) #1;
		clk_en <= 1'b0;
		exchange(16'h1234, 0);
		chk("held", 16'h0f0f, command.actuation_code);
		clk_en <= 1'b1;
	endtask
	// reset in mid-run clears the image, then a new exchange works
	task automatic mid_reset;
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		#1;
		chk("rst2", 3'h0, {image_valid, flog_on, sinfo_on});
		chk("rstimg", '0, in_image[1567:0]);
		exchange(16'h5aa5, 1);
		chk("code2", 16'h5aa5, command.actuation_code);
	endtask
	// reset, then the scenarios
	initial
	begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk) #1;
		chk("rst", 3'h0, {image_valid, flog_on, sinfo_on});
		chk("id", `SM_DEV_ID, dev_id);
		fixed_slots();
		fitted_and_options();
		frozen();
		mid_reset();
		final_report();
	end
endmodule // cyclic_io_slot_map_test
`default_nettype wire
